// ===== sdps_sequencer.sv
// Purpose: power state machine for sleep and deep sleep sequencing
// Assumes: one 10 MHz clock; inputs synchronous; AXI4-Lite slave
// Notes: idle request 01 is treated like sleep minus the broadcast
`include "sdps_consts.svh"

module sdps_sequencer
    import sdps_pkg::*;
#(
    parameter int NUM_UNITS = 4,
    parameter int PORT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic cpu_idle_req,
    input wire logic cpu_idle_ack,
    output logic sleep_broadcast,
    input wire logic [NUM_UNITS-1:0] sleep_disable_bit,
    input wire logic [NUM_UNITS-1:0] fast_shutoff_enable,
    input wire logic [NUM_UNITS-1:0] unit_bus_busy,
    input wire logic [NUM_UNITS-1:0] unit_op_busy,
    output logic [NUM_UNITS-1:0] unit_clk_en,
    output logic [NUM_UNITS-1:0] unit_abort,
    input wire logic irq_wake,
    input wire logic nmi_pin_n,
    input wire logic [15:0] watchdog_count,
    input wire logic power_on_reset_pin_n,
    input wire logic sw_reset_req,
    input wire logic pll_lock,
    output logic osc_pll_en,
    output logic sys_clk_en,
    output logic sys_reset,
    output logic nmi_trap,
    input wire logic [PORT_W-1:0] port_drive,
    output logic [PORT_W-1:0] port_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    sdps_state_type state_q;
    logic [1:0] req_q;
    logic deep_sleep_request_bit_q, reset_on_deep_wake_q, prot_q, armed_q, deep_entry_q;
    logic nmi_q, power_on_reset_pin_q;
    logic [15:0] wdt_q;
    logic [PORT_W-1:0] port_q;
    logic aw_q, w_q;
    logic [7:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_go, wake, deep_wake, nmi_fall, wdt_roll;
    logic units_quiet, drain_done;

    function automatic logic [31:0] rd_word(input logic [7:0] a);
        case (a)
            `SDPS_OFF_CON: rd_word = {30'h0, deep_sleep_request_bit_q, reset_on_deep_wake_q};
            `SDPS_OFF_CSR:
                rd_word = {21'h0, state_q, 6'h0, req_q};
            `SDPS_OFF_PLL: rd_word = {31'h0, pll_lock};
            `SDPS_OFF_PROT: rd_word = {31'h0, prot_q};
            default: rd_word = 32'h0000_0000;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // wake decode
    // ------------------------------------------------------------------
    assign nmi_fall = nmi_q && !nmi_pin_n;
    assign wdt_roll = (wdt_q == `SDPS_WDT_PRE) &&
        (watchdog_count == `SDPS_WDT_POST);
    // deep sleep has no clock: only power-on reset or nmi edge count
    assign deep_wake = !power_on_reset_pin_n || nmi_fall;
    assign wake = (state_q == SDPS_DEEP) ? deep_wake :
        (irq_wake || nmi_fall || wdt_roll || sw_reset_req ||
        !power_on_reset_pin_n);
    // sleeping units with a bus cycle open keep the clock alive
    assign units_quiet = ~|(unit_bus_busy & ~sleep_disable_bit);
    assign drain_done = units_quiet &&
        ~|(unit_op_busy & ~sleep_disable_bit & ~fast_shutoff_enable);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_q <= 1'b1;
            wdt_q <= 16'h0000;
            power_on_reset_pin_q <= 1'b0;
        end else begin
            nmi_q <= nmi_pin_n;
            wdt_q <= watchdog_count;
            power_on_reset_pin_q <= !power_on_reset_pin_n;
        end
    end

    // ------------------------------------------------------------------
    // power state machine
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= SDPS_WAIT_LOCK;
            deep_entry_q <= 1'b0;
        end else begin
            case (state_q)
                SDPS_WAIT_LOCK: begin
                    if (pll_lock && power_on_reset_pin_n) begin
                        state_q <= SDPS_RUN;
                    end
                end
                SDPS_RUN: begin
                    if (armed_q) begin
                        state_q <= SDPS_IDLE_REQ;
                        deep_entry_q <= 1'b1;
                    end else if (req_q != 2'h0 && req_q != 2'h3) begin
                        state_q <= SDPS_IDLE_REQ;
                        deep_entry_q <= 1'b0;
                    end
                end
                SDPS_IDLE_REQ: begin
                    if (wake) begin
                        state_q <= SDPS_RUN;
                    end else if (cpu_idle_ack) begin
                        state_q <= SDPS_IDLE_ACK;
                    end
                end
                SDPS_IDLE_ACK: begin
                    if (wake) begin
                        state_q <= SDPS_RUN;
                    end else if (deep_entry_q ||
                        req_q == `SDPS_REQ_SLEEP) begin
                        state_q <= SDPS_SLEEP;
                    end
                end
                SDPS_SLEEP: begin
                    if (wake && !deep_entry_q) begin
                        state_q <= SDPS_RUN;
                    end else if (deep_entry_q && drain_done) begin
                        state_q <= SDPS_DEEP;
                    end
                end
                SDPS_DEEP: begin
                    if (!power_on_reset_pin_n ||
                        (nmi_fall && reset_on_deep_wake_q)) begin
                        state_q <= SDPS_WAIT_LOCK;
                    end else if (nmi_fall) begin
                        state_q <= SDPS_RUN;
                    end
                    deep_entry_q <= !deep_wake;
                end
                default: state_q <= SDPS_WAIT_LOCK;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // outputs to cpu, units and clock system
    // ------------------------------------------------------------------
    always_comb begin
        cpu_idle_req = state_q inside {SDPS_IDLE_REQ, SDPS_IDLE_ACK,
            SDPS_SLEEP, SDPS_DEEP};
        sleep_broadcast = state_q inside {SDPS_SLEEP, SDPS_DEEP};
        osc_pll_en = state_q != SDPS_DEEP;
        sys_clk_en = state_q != SDPS_DEEP;
        sys_reset = state_q == SDPS_WAIT_LOCK;
    end

    // per unit gating: disabled units run on until deep sleep, fast ones stop as soon as no bus cycle is open
    genvar gi;
    generate
        for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
            always_comb begin
                if (state_q == SDPS_DEEP) begin
                    unit_clk_en[gi] = 1'b0;
                    unit_abort[gi] = 1'b0;
                end else if (!sleep_broadcast || sleep_disable_bit[gi]) begin
                    unit_clk_en[gi] = 1'b1;
                    unit_abort[gi] = 1'b0;
                end else if (unit_bus_busy[gi]) begin
                    unit_clk_en[gi] = 1'b1;
                    unit_abort[gi] = 1'b0;
                end else if (fast_shutoff_enable[gi]) begin
                    unit_clk_en[gi] = 1'b0;
                    unit_abort[gi] = unit_op_busy[gi];
                end else begin
                    unit_clk_en[gi] = unit_op_busy[gi];
                    unit_abort[gi] = 1'b0;
                end
            end
        end
    endgenerate

    // ports freeze on deep sleep; a reset wake returns them to zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_q <= '0;
        end else if (state_q == SDPS_WAIT_LOCK) begin
            port_q <= '0;
        end else if (state_q != SDPS_DEEP) begin
            port_q <= port_drive;
        end
    end
    assign port_out = port_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            nmi_trap <= 1'b0;
        end else begin
            nmi_trap <= nmi_fall && state_q != SDPS_DEEP;
        end
    end

    // ------------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------------
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (rd_word(awaddr_q) == 32'h0 &&
                    awaddr_q != `SDPS_OFF_CON && awaddr_q != `SDPS_OFF_CSR &&
                    awaddr_q != `SDPS_OFF_PLL && awaddr_q != `SDPS_OFF_PROT)
                    ? 2'h2 : 2'h0;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word({s_axi_araddr[7:2], 2'h0});
            s_axi_rresp <= (s_axi_araddr[7:2] inside {6'hC, 6'hD, 6'hE, 6'hF})
                ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // protect write needs every byte lane, a partial write is dropped
    function automatic logic wstrb_ok(input logic [3:0] need);
        wstrb_ok = (wstrb_q & need) == need;
    endfunction

    // protect word: low bit is the flag, upper half must carry password
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            prot_q <= 1'b1;
            reset_on_deep_wake_q <= 1'b1;
            deep_sleep_request_bit_q <= 1'b0;
            armed_q <= 1'b0;
            req_q <= 2'h0;
        end else begin
            if (wr_go && awaddr_q == `SDPS_OFF_PROT && wstrb_ok(4'hF) &&
                wdata_q[31:16] == `SDPS_PROT_PASSWORD) begin
                prot_q <= wdata_q[`SDPS_PROT_BIT];
            end
            if (wr_go && awaddr_q == `SDPS_OFF_CON &&
                !prot_q) begin
                reset_on_deep_wake_q <= wdata_q[`SDPS_CON_RESET_ON_DEEP_WAKE];
                deep_sleep_request_bit_q <= wdata_q[`SDPS_CON_DEEP_SLEEP_REQUEST_BIT];
            end
            // request arms only once the protect flag is set again
            if (deep_sleep_request_bit_q && prot_q && state_q == SDPS_RUN) begin
                armed_q <= 1'b1;
            end
            if (wr_go && awaddr_q == `SDPS_OFF_CSR) begin
                req_q <= wdata_q[1:0];
            end
            if (state_q == SDPS_DEEP && deep_wake) begin
                deep_sleep_request_bit_q <= 1'b0;
                armed_q <= 1'b0;
            end
            // a wake in the same cycle as a write still clears the field
            if (state_q inside {SDPS_IDLE_REQ, SDPS_IDLE_ACK, SDPS_SLEEP,
                SDPS_DEEP} && wake) begin
                req_q <= 2'h0;
            end
        end
    end

endmodule // sdps_sequencer

// ===== sdps_consts.svh
// Purpose: constants for the sleep / deep sleep power sequencer
// Assumes: AXI4-Lite register slave, 32-bit words, byte addresses
// Notes: offsets are byte addresses of the register window
//
// Functional notes
// - writing 10 to the sleep request field starts sleep entry
// - sleep entry: cpu idle handshake first, then broadcast sleep
// - units with sleep disable set ignore sleep and keep running
// - enabled units finish their bus transaction, then suspend
// - fast shutoff stops clocks at once; otherwise finish work first
// - sleep ends on idle wake events; units resume run operation
// - deep sleep request bit sits in its own control register
// - control writes only while init-end protect is 0; armed at 1
// - deep sleep: idle handshake, sleep broadcast, then clocks off
// - port pins hold their value throughout deep sleep
// - deep sleep exits only on power-on reset or nmi falling edge
// - power-on wake runs full reset until pll lock and pin released
// - nmi wake with reset-on-wake runs reset, ports to reset state
// - nmi wake without reset resumes on pll clocks, ports held
// - pll lock status bit is readable for software polling
// - sleep keeps osc, pll, watchdog running; deep sleep stops all
// - state code: 0 lock,1 run,2 idle req,3 idle ack,4 sleep,5 deep
// - any wake event clears the sleep request field
// - wake: interrupt, nmi, watchdog 7FFF to 8000, reset, sw reset
// - hardware clears deep sleep request on any deep sleep wake
`ifndef SDPS_CONSTS_SVH
`define SDPS_CONSTS_SVH

// ----------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------
`define SDPS_OFF_CON 8'h30
`define SDPS_OFF_CSR 8'h34
`define SDPS_OFF_PLL 8'h38
`define SDPS_OFF_PROT 8'h3C
`define SDPS_CON_RESET 32'h0000_0001
`define SDPS_CSR_RESET 32'h0000_0100

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define SDPS_CON_RESET_ON_DEEP_WAKE 0
`define SDPS_CON_DEEP_SLEEP_REQUEST_BIT 1
`define SDPS_CSR_REQ_LSB 0
`define SDPS_CSR_POWER_STATE_CODE_LSB 8
`define SDPS_PLL_LOCK 0
`define SDPS_PROT_BIT 0
`define SDPS_REQ_SLEEP 2'h2
`define SDPS_WDT_PRE 16'h7FFF
`define SDPS_WDT_POST 16'h8000
`define SDPS_PROT_PASSWORD 16'hA5C3

`endif

// ===== sdps_pkg.sv
// Purpose: types for the sleep / deep sleep power sequencer
// Assumes: nothing beyond SystemVerilog
// Notes: state codes follow the status field encoding
package sdps_pkg;
    typedef enum logic [2:0] {
        SDPS_WAIT_LOCK,
        SDPS_RUN,
        SDPS_IDLE_REQ,
        SDPS_IDLE_ACK,
        SDPS_SLEEP,
        SDPS_DEEP
    } sdps_state_type;
endpackage

// ===== sdps_sequencer_props.sv
// Purpose: port assertions for the power sequencer
// Assumes: one clock domain, rst async active high
// Notes: bound to every sdps_sequencer instance
module sdps_sequencer_props #(
    parameter int NUM_UNITS = 4,
    parameter int PORT_W = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_idle_req,
    input wire logic cpu_idle_ack,
    input wire logic sleep_broadcast,
    input wire logic [NUM_UNITS-1:0] sleep_disable_bit,
    input wire logic [NUM_UNITS-1:0] fast_shutoff_enable,
    input wire logic [NUM_UNITS-1:0] unit_bus_busy,
    input wire logic [NUM_UNITS-1:0] unit_op_busy,
    input wire logic [NUM_UNITS-1:0] unit_clk_en,
    input wire logic nmi_pin_n,
    input wire logic power_on_reset_pin_n,
    input wire logic pll_lock,
    input wire logic osc_pll_en,
    input wire logic sys_clk_en,
    input wire logic sys_reset,
    input wire logic [PORT_W-1:0] port_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // unit rules only apply while clocks still run
    wire slp = sleep_broadcast && osc_pll_en;
    property p_ack; $rose(sleep_broadcast) |-> $past(cpu_idle_ack); endproperty
    a_ack: assert property (p_ack) else $error("sleep before ack");
    property p_req; sleep_broadcast |-> cpu_idle_req; endproperty
    a_req: assert property (p_req) else $error("no idle request");
    property p_deep; !osc_pll_en |-> sleep_broadcast && !sys_clk_en; endproperty
    a_deep: assert property (p_deep) else $error("deep order");
    property p_hold;
        !osc_pll_en && $past(!osc_pll_en) |-> $stable(port_out);
    endproperty
    a_hold: assert property (p_hold) else $error("port moved");
    property p_quiet;
        $fell(osc_pll_en) |->
            $past((unit_bus_busy & ~sleep_disable_bit) == '0);
    endproperty
    a_quiet: assert property (p_quiet) else $error("bus cut");
    property p_ign;
        slp |-> (unit_clk_en & sleep_disable_bit) == sleep_disable_bit;
    endproperty
    a_ign: assert property (p_ign) else $error("unit slept");
    property p_bus; slp |-> (~unit_clk_en & unit_bus_busy) == '0; endproperty
    a_bus: assert property (p_bus) else $error("bus not finished");
    property p_fast;
        slp |-> (unit_clk_en & fast_shutoff_enable & ~sleep_disable_bit
            & ~unit_bus_busy) == '0;
    endproperty
    a_fast: assert property (p_fast) else $error("fast stop late");
    property p_slow;
        slp |-> (~unit_clk_en & ~fast_shutoff_enable & unit_op_busy) == '0;
    endproperty
    a_slow: assert property (p_slow) else $error("work cut");
    property p_exit;
        $rose(osc_pll_en) |-> !$past(power_on_reset_pin_n)
            || ($past(nmi_pin_n, 2) && !$past(nmi_pin_n));
    endproperty
    a_exit: assert property (p_exit) else $error("bad deep exit");
    property p_lock;
        $fell(sys_reset) |-> $past(pll_lock && power_on_reset_pin_n);
    endproperty
    a_lock: assert property (p_lock) else $error("early exit");
    c_sleep: cover property ($rose(sleep_broadcast));
    c_deep: cover property ($fell(osc_pll_en));
    c_wake: cover property ($rose(osc_pll_en));
endmodule // sdps_sequencer_props

bind sdps_sequencer sdps_sequencer_props #(
    .NUM_UNITS(NUM_UNITS), .PORT_W(PORT_W)
) sdps_sequencer_props_inst (
    .clk, .rst, .cpu_idle_req, .cpu_idle_ack, .sleep_broadcast,
    .sleep_disable_bit, .fast_shutoff_enable, .unit_bus_busy,
    .unit_op_busy, .unit_clk_en, .nmi_pin_n, .power_on_reset_pin_n,
    .pll_lock, .osc_pll_en, .sys_clk_en, .sys_reset, .port_out
);

// ===== sdps_cpu_model.sv
// Purpose: cpu side of the idle handshake
// Assumes: ack is a level held while the request stands
// Notes: delay set per test, so slow and prompt cpus are both seen
module sdps_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic cpu_idle_req,
    input wire logic [3:0] ack_dly,
    output logic cpu_idle_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q;
    // a real core finishes its instruction first, hence the wait
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            cpu_idle_ack <= 1'b0;
        end else if (!cpu_idle_req) begin
            cnt_q <= 4'h0;
            cpu_idle_ack <= 1'b0;
        end else if (cnt_q >= ack_dly) begin
            cpu_idle_ack <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule // sdps_cpu_model

// ===== tb_sdps_sequencer.sv
// Purpose: self-checking bench for the power sequencer
// Assumes: cpu model acks after a random delay
// Notes: bus waits are bounded by the watchdog process
`include "sdps_consts.svh"
module tb_sdps_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
    logic s_axi_awready, s_axi_wready, s_axi_arready;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic cpu_idle_req, cpu_idle_ack, sleep_broadcast, irq_wake = 0;
    logic nmi_pin_n = 1, power_on_reset_pin_n = 1, sw_reset_req = 0;
    logic pll_lock = 1, osc_pll_en, sys_clk_en, sys_reset, nmi_trap;
    logic [3:0] sleep_disable_bit = 0, fast_shutoff_enable = 0, ack_dly = 1;
    logic [3:0] unit_bus_busy = 0, unit_op_busy = 0, unit_clk_en, unit_abort;
    logic [15:0] watchdog_count = 0, port_drive = 16'h1234, port_out, held;
    int trap_cnt = 0, trap_base = 0;
    int num_errors = 0, cmp_count = 0;
    sdps_sequencer sdps_sequencer_inst (
        .clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .cpu_idle_req, .cpu_idle_ack,
        .sleep_broadcast, .sleep_disable_bit, .fast_shutoff_enable,
        .unit_bus_busy, .unit_op_busy, .unit_clk_en, .unit_abort, .irq_wake,
        .nmi_pin_n, .watchdog_count, .power_on_reset_pin_n, .sw_reset_req,
        .pll_lock, .osc_pll_en, .sys_clk_en, .sys_reset, .nmi_trap,
        .port_drive, .port_out
    );
    sdps_cpu_model sdps_cpu_model_inst (
        .clk, .rst, .cpu_idle_req, .ack_dly, .cpu_idle_ack
    );
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (nmi_trap) trap_cnt <= trap_cnt + 1;
    end
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // expected {abort, clock enable} of the units under the sleep signal
    function automatic logic [7:0] exp_unit(input logic slp);
        logic [3:0] en, ab;
        en = slp ? (sleep_disable_bit | unit_bus_busy |
            (~fast_shutoff_enable & unit_op_busy)) : 4'hF;
        ab = slp ? (~sleep_disable_bit & ~unit_bus_busy &
            fast_shutoff_enable & unit_op_busy) : 4'h0;
        exp_unit = {ab, en};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = 2'h0);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 0;
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, r);
    endtask
    // enter deep sleep with busy units, then wake by nmi or power-on
    task automatic deep(input logic reset_on_deep_wake, input logic por);
        wr(`SDPS_OFF_PROT, 32'hA5C3_0000);
        wr(`SDPS_OFF_CON, {30'h0, 1'b1, reset_on_deep_wake});
        rd(`SDPS_OFF_CON, {30'h0, 1'b1, reset_on_deep_wake}, 2'h0);
        rd(`SDPS_OFF_CSR, 32'h100, 2'h0);
        sleep_disable_bit <= 4'($urandom) & 4'h7;
        unit_bus_busy <= 4'hF;
        wr(`SDPS_OFF_PROT, 32'hA5C3_0001);
        wait (sleep_broadcast);
        repeat (6) @(posedge clk);
        chk(osc_pll_en, 1);
        unit_bus_busy <= 0;
        unit_op_busy <= 0;
        wait (!osc_pll_en);
        @(posedge clk);
        held = port_out;
        port_drive <= ~port_drive;
        irq_wake <= 1;
        watchdog_count <= 16'h7FFF;
        @(posedge clk);
        watchdog_count <= 16'h8000;
        repeat (3) @(posedge clk);
        irq_wake <= 0;
        pll_lock <= 0;
        chk(osc_pll_en, 0);
        chk(port_out, held);
        if (por) power_on_reset_pin_n <= 0;
        else nmi_pin_n <= 0;
        repeat (4) @(posedge clk);
        power_on_reset_pin_n <= 1;
        nmi_pin_n <= 1; // held until clocks run
        chk(sys_reset, reset_on_deep_wake);
        chk(osc_pll_en, 1);
        if (reset_on_deep_wake) chk(port_out, 0);
        rd(`SDPS_OFF_CSR, reset_on_deep_wake ? 32'h0 : 32'h100, 2'h0);
        rd(`SDPS_OFF_PLL, 0, 2'h0);
        pll_lock <= 1;
        rd(`SDPS_OFF_PLL, 1, 2'h0);
        chk(sys_reset, 0);
        rd(`SDPS_OFF_CON, {31'h0, reset_on_deep_wake}, 2'h0);
        $display("test deep %0d %0d done", reset_on_deep_wake, por);
    endtask
    task automatic end_of_test;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        end_of_test;
    end
    initial begin
        void'($urandom(49));
        repeat (8) @(posedge clk);
        rst <= 0;
        rd(`SDPS_OFF_CON, 1, 2'h0);
        rd(`SDPS_OFF_CSR, 32'h100, 2'h0);
        rd(8'h00, 0, 2'h2);
        wr(8'h00, 0, 2'h2);
        wr(`SDPS_OFF_CON, 3);
        rd(`SDPS_OFF_CON, 1, 2'h0);
        // k: 0 irq, 1 watchdog, 2 nmi, 3 idle request only
        for (int k = 0; k < 4; k++) begin
            sleep_disable_bit <= 4'($urandom);
            fast_shutoff_enable <= 4'($urandom);
            unit_bus_busy <= 4'($urandom);
            unit_op_busy <= 4'($urandom);
            ack_dly <= 4'($urandom_range(1, 8));
            wr(`SDPS_OFF_CSR, k == 3 ? 32'h1 : 32'h2);
            wait (cpu_idle_ack);
            repeat (2) @(posedge clk);
            rd(`SDPS_OFF_CSR, k == 3 ? 32'h301 : 32'h402, 2'h0);
            chk(sleep_broadcast, k != 3);
            chk(osc_pll_en, 1);
            chk(cpu_idle_req, 1);
            chk({unit_abort, unit_clk_en}, exp_unit(k != 3));
            trap_base = trap_cnt;
            if (k == 1) watchdog_count <= 16'h7FFF;
            else if (k == 2) nmi_pin_n <= 0;
            else irq_wake <= 1;
            @(posedge clk);
            watchdog_count <= 16'h8000;
            repeat (2) @(posedge clk);
            irq_wake <= 0;
            nmi_pin_n <= 1;
            rd(`SDPS_OFF_CSR, 32'h100, 2'h0);
            chk(trap_cnt - trap_base, k == 2);
            $display("test sleep %0d done", k);
        end
        deep(0, 0);
        deep(1, 0);
        deep(1, 1);
        end_of_test;
    end
endmodule // tb_sdps_sequencer
